/* hdl/rxmirq_bank.sv */
/*
 * Register bank and event flags of the receiver measurement block.
 * Assumes the analog and radio side (correction loop, strength sampler, mode
 * sequencer, synthesizer, sync detector, buffer) sits on sys_clk and gives
 * one-cycle done/event pulses and levels; no synchronisers are needed.
 */
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module rxmirq_bank #(
    parameter int CORR_W = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire logic [2:0]  op_mode,
    input  wire logic        mode_reached,
    input  wire logic        intermediate_mode,
    input  wire logic        synth_lock,
    input  wire logic        gain_done,
    input  wire logic        continuous_mode,
    input  wire logic        bit_tick,
    input  wire logic        buffer_empty,
    input  wire logic        frame_start_det,
    input  wire logic        post_level_expired,
    input  wire logic        corr_done,
    input  wire logic [15:0] corr_result,
    input  wire logic        err_done,
    input  wire logic [15:0] err_result,
    input  wire logic        strength_sample_done,
    input  wire logic [7:0]  strength_sample,
    output logic             corr_run,
    output logic             strength_run,
    output logic [1:0]       pin0_function,
    output logic [1:0]       pin1_function,
    output logic [1:0]       pin2_function,
    output logic [1:0]       pin3_function,
    output logic [1:0]       pin4_function,
    output logic [1:0]       pin5_function,
    output logic [2:0]       clock_output_divider,
    output logic [7:0]       rx_entry_wait,
    output logic [7:0]       post_level_wait
);
    initial begin
        if (CORR_W != 16) $error("rxmirq_bank: correction width must be 16");
    end

    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        logic        clear_before_phase;
        logic        correct_on_rx_entry;
        logic        corr_busy;
        logic        corr_done_flag;
        logic [15:0] freq_correction_value;
        logic [15:0] freq_error_value;
        logic        strength_busy;
        logic [7:0]  strength_level;
        logic [7:0]  strength_trigger_level;
        logic [7:0]  pin_sel_a;
        logic [1:0]  pin4_sel;
        logic [1:0]  pin5_sel;
        logic [2:0]  clk_div;
        logic [7:0]  rx_wait;
        logic [7:0]  post_wait;
        logic [2:0]  mode_prev;
        logic        mode_settled;
        logic        receive_settled;
        logic        gain_seen;
        logic        corr_seen;
        logic        strength_seen;
        logic        over_level;
        logic        timeout;
        logic        frame_start_match;
        logic        inter_prev;
        logic        intermediate_mode_active;
        logic [11:0] wait_cnt;
        logic        wait_armed;
        logic        rx_start;
        logic [7:0]  rdata;
    } rxmirq_state_t;

    rxmirq_state_t s_q;
    rxmirq_state_t s_d;

    logic in_rx;
    logic rx_enter;
    logic rx_leave;
    logic mode_change;
    logic wr_cc;
    logic wr_sc;
    logic wr_fl;
    logic start_corr;
    logic [7:0] rd_mux;

    assign in_rx       = (op_mode == rxmirq_pkg::MODE_RX);
    assign mode_change = (op_mode != s_q.mode_prev);
    assign rx_enter    = in_rx && mode_change;
    assign rx_leave    = !in_rx && (s_q.mode_prev == rxmirq_pkg::MODE_RX);
    assign wr_cc       = reg_wr && (reg_addr == rxmirq_pkg::ADDR_CORR_CTRL);
    assign wr_sc       = reg_wr && (reg_addr == rxmirq_pkg::ADDR_STR_CTRL);
    assign wr_fl       = reg_wr && (reg_addr == rxmirq_pkg::ADDR_FLAGS1);
    // Correction start: manual trigger, or receive entry when automatic
    assign start_corr  = (wr_cc && reg_wdata[rxmirq_pkg::CC_TRIGGER])
                       || (rx_enter && s_q.correct_on_rx_entry);

    // ********************************************
    // Read mux
    // ********************************************
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            rxmirq_pkg::ADDR_CORR_CTRL: begin
                rd_mux[rxmirq_pkg::CC_CORR_DONE]   = s_q.corr_done_flag;
                rd_mux[rxmirq_pkg::CC_CLEAR_PHASE] = s_q.clear_before_phase;
                rd_mux[rxmirq_pkg::CC_ON_ENTRY]    = s_q.correct_on_rx_entry;
            end
            rxmirq_pkg::ADDR_CORR_HI:   rd_mux = s_q.freq_correction_value[15:8];
            rxmirq_pkg::ADDR_CORR_LO:   rd_mux = s_q.freq_correction_value[7:0];
            rxmirq_pkg::ADDR_ERR_HI:    rd_mux = s_q.freq_error_value[15:8];
            rxmirq_pkg::ADDR_ERR_LO:    rd_mux = s_q.freq_error_value[7:0];
            rxmirq_pkg::ADDR_STR_CTRL:  rd_mux[rxmirq_pkg::SC_DONE] = !s_q.strength_busy;
            rxmirq_pkg::ADDR_STR_LEVEL: rd_mux = s_q.strength_level;
            rxmirq_pkg::ADDR_PIN_SEL_A: rd_mux = s_q.pin_sel_a;
            rxmirq_pkg::ADDR_PIN_SEL_B: rd_mux = {s_q.pin4_sel, s_q.pin5_sel, 1'b0, s_q.clk_div};
            rxmirq_pkg::ADDR_FLAGS1: begin
                rd_mux[rxmirq_pkg::FL_MODE_SET] = s_q.mode_settled;
                rd_mux[rxmirq_pkg::FL_RX_SET]   = s_q.receive_settled;
                // Lock bit is a live view, qualified by mode
                rd_mux[rxmirq_pkg::FL_LOCK]     = synth_lock && (in_rx
                                                || op_mode == rxmirq_pkg::MODE_SYNTH);
                rd_mux[rxmirq_pkg::FL_OVER]     = s_q.over_level;
                rd_mux[rxmirq_pkg::FL_TIMEOUT]  = s_q.timeout;
                rd_mux[rxmirq_pkg::FL_INTER]    = s_q.intermediate_mode_active;
                rd_mux[rxmirq_pkg::FL_FRAME]    = s_q.frame_start_match;
            end
            rxmirq_pkg::ADDR_STR_THR:   rd_mux = s_q.strength_trigger_level;
            rxmirq_pkg::ADDR_RX_WAIT:   rd_mux = s_q.rx_wait;
            rxmirq_pkg::ADDR_POST_WAIT: rd_mux = s_q.post_wait;
            default:                    rd_mux = 8'h00;
        endcase
    end

    // ********************************************
    // Next state
    // ********************************************
    always_comb begin
        s_d = s_q;
        s_d.mode_prev  = op_mode;
        s_d.inter_prev = intermediate_mode;
        s_d.rx_start   = 1'b0;
        if (reg_rd) begin
            s_d.rdata = rd_mux;
        end

        // Configuration writes; trigger bits are never stored
        if (wr_cc) begin
            s_d.clear_before_phase  = reg_wdata[rxmirq_pkg::CC_CLEAR_PHASE];
            s_d.correct_on_rx_entry = reg_wdata[rxmirq_pkg::CC_ON_ENTRY];
        end
        if (reg_wr && reg_addr == rxmirq_pkg::ADDR_PIN_SEL_A) begin
            s_d.pin_sel_a = reg_wdata;
        end
        if (reg_wr && reg_addr == rxmirq_pkg::ADDR_PIN_SEL_B) begin
            s_d.pin4_sel = reg_wdata[7:6];
            s_d.pin5_sel = reg_wdata[5:4];
            s_d.clk_div  = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == rxmirq_pkg::ADDR_STR_THR) begin
            s_d.strength_trigger_level = reg_wdata;
        end
        if (reg_wr && reg_addr == rxmirq_pkg::ADDR_RX_WAIT) begin
            s_d.rx_wait = reg_wdata;
        end
        if (reg_wr && reg_addr == rxmirq_pkg::ADDR_POST_WAIT) begin
            s_d.post_wait = reg_wdata;
        end

        // ********************************************
        // Frequency correction
        // ********************************************
        if (wr_cc && reg_wdata[rxmirq_pkg::CC_RES_CLEAR] && in_rx) begin
            s_d.freq_correction_value = 16'h0000;
        end
        if (start_corr) begin
            s_d.corr_busy      = 1'b1;
            s_d.corr_done_flag = 1'b0;
            s_d.corr_seen      = 1'b0;
            // Zeroing only applies in automatic mode
            if (s_q.clear_before_phase && s_q.correct_on_rx_entry) begin
                s_d.freq_correction_value = 16'h0000;
            end
        end else if (s_q.corr_busy && corr_done) begin
            s_d.corr_busy             = 1'b0;
            s_d.corr_done_flag        = 1'b1;
            s_d.corr_seen             = 1'b1;
            s_d.freq_correction_value = corr_result;
        end
        if (err_done) begin
            s_d.freq_error_value = err_result;
        end

        // ********************************************
        // Strength measurement
        // ********************************************
        if (wr_sc && reg_wdata[rxmirq_pkg::SC_TRIGGER]) begin
            s_d.strength_busy = 1'b1;
        end else if (strength_sample_done) begin
            s_d.strength_busy  = 1'b0;
            s_d.strength_level = strength_sample;
            s_d.strength_seen  = in_rx;
            // Larger magnitude means weaker signal, so "over" is numerically below
            if (in_rx && strength_sample < s_q.strength_trigger_level) begin
                s_d.over_level = 1'b1;
            end
        end
        if (gain_done && in_rx) begin
            s_d.gain_seen = 1'b1;
        end

        // ********************************************
        // Flags
        // ********************************************
        if (mode_change) begin
            s_d.mode_settled = 1'b0;
        end else if (mode_reached) begin
            s_d.mode_settled = 1'b1;
        end
        if (in_rx && s_q.strength_seen && s_q.gain_seen && s_q.corr_seen) begin
            s_d.receive_settled = 1'b1;
        end
        if (intermediate_mode && !s_q.inter_prev) begin
            s_d.intermediate_mode_active = 1'b1;
        end else if (!intermediate_mode && s_q.inter_prev) begin
            s_d.intermediate_mode_active = 1'b0;
        end

        // Host clears; a same-cycle frame-start set below wins, an over-level set above does not
        if (wr_fl && reg_wdata[rxmirq_pkg::FL_OVER]) begin
            s_d.over_level = 1'b0;
        end
        if (wr_fl && reg_wdata[rxmirq_pkg::FL_FRAME] && continuous_mode) begin
            s_d.frame_start_match = 1'b0;
        end
        if (buffer_empty) begin
            s_d.timeout           = 1'b0;
            s_d.frame_start_match = 1'b0;
        end
        if (in_rx && frame_start_det) begin
            s_d.frame_start_match = 1'b1;
        end

        // First timeout: counts bit periods until level event or expiry
        if (rx_enter) begin
            s_d.wait_armed = (s_q.rx_wait != 8'h00);
            s_d.wait_cnt   = 12'h000;
        end else if (s_q.wait_armed) begin
            if (s_d.over_level) begin
                s_d.wait_armed = 1'b0;
            end else if (bit_tick) begin
                if (s_q.wait_cnt == 12'({s_q.rx_wait, 4'h0}) - 12'h001) begin
                    s_d.wait_armed = 1'b0;
                    s_d.timeout    = 1'b1;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt + 12'h001;
                end
            end
        end
        if (in_rx && post_level_expired) begin
            s_d.timeout = 1'b1;
        end

        // Leaving receive clears receive-only state
        if (rx_leave) begin
            s_d.receive_settled   = 1'b0;
            s_d.over_level        = 1'b0;
            s_d.timeout           = 1'b0;
            s_d.frame_start_match = 1'b0;
            s_d.gain_seen         = 1'b0;
            s_d.corr_seen         = 1'b0;
            s_d.strength_seen     = 1'b0;
            s_d.wait_armed        = 1'b0;
        end
        s_d.rx_start = start_corr;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.strength_level         <= rxmirq_pkg::RST_STR_LEVEL;
            s_q.strength_trigger_level <= rxmirq_pkg::RST_STR_THR;
            s_q.pin_sel_a              <= rxmirq_pkg::RST_PIN_A;
            s_q.pin4_sel               <= rxmirq_pkg::RST_PIN_B;
            s_q.pin5_sel               <= rxmirq_pkg::RST_PIN_B;
            s_q.clk_div                <= rxmirq_pkg::RST_CLK_DIV;
            s_q.rx_wait                <= rxmirq_pkg::RST_WAIT;
            s_q.post_wait              <= rxmirq_pkg::RST_WAIT;
            s_q.mode_settled           <= 1'b1;
            // Start from the live mode so release of reset is not seen as a mode change
            s_q.mode_prev              <= op_mode;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign reg_rdata            = s_q.rdata;
    assign corr_run             = s_q.rx_start;
    assign strength_run         = s_q.strength_busy;
    assign pin0_function        = s_q.pin_sel_a[7:6];
    assign pin1_function        = s_q.pin_sel_a[5:4];
    assign pin2_function        = s_q.pin_sel_a[3:2];
    assign pin3_function        = s_q.pin_sel_a[1:0];
    assign pin4_function        = s_q.pin4_sel;
    assign pin5_function        = s_q.pin5_sel;
    assign clock_output_divider = s_q.clk_div;
    assign rx_entry_wait        = s_q.rx_wait;
    assign post_level_wait      = s_q.post_wait;
endmodule : rxmirq_bank
`default_nettype wire

/* hdl/rxmirq_pkg.sv */
/*
 * Package of the receiver measurement and event flag register bank: offsets,
 * field positions, reset values, mode codes and timing counts.
 * Assumes a byte-wide register port with seven-bit addresses.
 */
package rxmirq_pkg;
    localparam logic [6:0] ADDR_CORR_CTRL = 7'h1e;
    localparam logic [6:0] ADDR_CORR_HI   = 7'h1f;
    localparam logic [6:0] ADDR_CORR_LO   = 7'h20;
    localparam logic [6:0] ADDR_ERR_HI    = 7'h21;
    localparam logic [6:0] ADDR_ERR_LO    = 7'h22;
    localparam logic [6:0] ADDR_STR_CTRL  = 7'h23;
    localparam logic [6:0] ADDR_STR_LEVEL = 7'h24;
    localparam logic [6:0] ADDR_PIN_SEL_A = 7'h25;
    localparam logic [6:0] ADDR_PIN_SEL_B = 7'h26;
    localparam logic [6:0] ADDR_FLAGS1    = 7'h27;
    localparam logic [6:0] ADDR_STR_THR   = 7'h29;
    localparam logic [6:0] ADDR_RX_WAIT   = 7'h2a;
    localparam logic [6:0] ADDR_POST_WAIT = 7'h2b;

    // Correction control fields
    localparam int CC_CLEAR_PHASE = 3;
    localparam int CC_ON_ENTRY    = 2;
    localparam int CC_RES_CLEAR   = 1;
    localparam int CC_TRIGGER     = 0;
    localparam int CC_CORR_DONE   = 4;
    // Strength control fields
    localparam int SC_DONE        = 1;
    localparam int SC_TRIGGER     = 0;
    // Flag positions
    localparam int FL_MODE_SET    = 7;
    localparam int FL_RX_SET      = 6;
    localparam int FL_LOCK        = 4;
    localparam int FL_OVER        = 3;
    localparam int FL_TIMEOUT     = 2;
    localparam int FL_INTER       = 1;
    localparam int FL_FRAME       = 0;

    localparam logic [7:0] RST_STR_LEVEL = 8'hff;
    localparam logic [7:0] RST_STR_THR   = 8'he4;
    localparam logic [7:0] RST_PIN_A     = 8'h00;
    localparam logic [1:0] RST_PIN_B     = 2'h0;
    localparam logic [2:0] RST_CLK_DIV   = 3'h7;
    localparam logic [7:0] RST_WAIT      = 8'h00;

    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STBY  = 3'h1;
    localparam logic [2:0] MODE_SYNTH = 3'h2;
    localparam logic [2:0] MODE_RX    = 3'h4;

    localparam int TIMEOUT_BITS = 16;
endpackage : rxmirq_pkg

/* dv/rxmirq_bank_chk.sv */
/* Port-level assertions for the receiver measurement register bank.
   Assumes binding onto every rxmirq_bank instance; one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module rxmirq_chk (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] op_mode,
    input wire logic       synth_lock,
    input wire logic       strength_sample_done,
    input wire logic       corr_run,
    input wire logic       strength_run
);
    // ****************************************
    // Properties
    // ****************************************
    wire logic lock_live;
    assign lock_live = synth_lock && (op_mode == rxmirq_pkg::MODE_SYNTH || op_mode == rxmirq_pkg::MODE_RX);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_corr_trig;
        reg_wr && reg_addr == rxmirq_pkg::ADDR_CORR_CTRL && reg_wdata[0] |=> corr_run;
    endproperty
    a_corr_trig: assert property (p_corr_trig) else $error("no correction run");
    property p_str_trig;
        reg_wr && reg_addr == rxmirq_pkg::ADDR_STR_CTRL && reg_wdata[0] |=> strength_run;
    endproperty
    a_str_trig: assert property (p_str_trig) else $error("no strength run");
    property p_str_hold;
        strength_run && !strength_sample_done |=> strength_run;
    endproperty
    a_str_hold: assert property (p_str_hold) else $error("strength run dropped early");
    property p_str_done;
        reg_rd && reg_addr == rxmirq_pkg::ADDR_STR_CTRL && strength_run |-> ##1 !reg_rdata[1];
    endproperty
    a_str_done: assert property (p_str_done) else $error("done shown while busy");
    property p_ctrl_rd;
        reg_rd && reg_addr == rxmirq_pkg::ADDR_CORR_CTRL |=> reg_rdata[1:0] == 2'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("trigger bits read back");
    property p_str_rd;
        reg_rd && reg_addr == rxmirq_pkg::ADDR_STR_CTRL |=> reg_rdata[7:2] == 6'h00 && !reg_rdata[0];
    endproperty
    a_str_rd: assert property (p_str_rd) else $error("strength control bits");
    property p_lock;
        reg_rd && reg_addr == rxmirq_pkg::ADDR_FLAGS1 |=> reg_rdata[4] == $past(lock_live);
    endproperty
    a_lock: assert property (p_lock) else $error("lock flag wrong");
    property p_unmapped;
        reg_rd && reg_addr == 7'h00 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : rxmirq_chk
bind rxmirq_bank rxmirq_chk u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .op_mode, .synth_lock, .strength_sample_done, .corr_run, .strength_run);
`default_nettype wire

/* dv/rxmirq_radio_model.sv */
/* Behavioural radio side: correction loop, error meter and strength sampler.
   Assumes corr_run pulses and strength_run levels on sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module rxmirq_radio_model #(
    parameter int          LAT      = 20,
    parameter logic [15:0] CORR_VAL = 16'h8123,
    parameter logic [15:0] ERR_VAL  = 16'hfe02,
    parameter logic [7:0]  SAMPLE   = 8'h50
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        corr_run,
    input  wire logic        strength_run,
    output var  logic        corr_done,
    output wire logic [15:0] corr_result,
    output wire logic        err_done,
    output wire logic [15:0] err_result,
    output var  logic        strength_sample_done,
    output wire logic [7:0]  strength_sample
);
    // ****************************************
    // Measurement timing
    // ****************************************
    int cc;
    int sc;
    // Buses show the inverse outside the done cycle so a late capture is caught
    assign corr_result     = corr_done ? CORR_VAL : ~CORR_VAL;
    assign err_result      = corr_done ? ERR_VAL : ~ERR_VAL;
    assign err_done        = corr_done;
    assign strength_sample = strength_sample_done ? SAMPLE : ~SAMPLE;
    always_ff @(posedge sys_clk) begin
        corr_done <= 1'b0;
        strength_sample_done <= 1'b0;
        if (rst) begin
            cc <= 0;
            sc <= 0;
        end else begin
            if (corr_run) cc <= LAT;
            else if (cc > 0) cc <= cc - 1;
            if (cc == 1) corr_done <= 1'b1;
            sc <= strength_run ? sc + 1 : 0;
            if (strength_run && sc == LAT) strength_sample_done <= 1'b1;
        end
    end
endmodule : rxmirq_radio_model
`default_nettype wire

/* dv/rx_measure_and_irq_flags_test.sv */
/* Self-checking bench for rxmirq_bank with the radio model on its far side.
   Assumes the checker is bound in; all events other than the model's done pulses are driven from here. */
`timescale 1ns/10ps
`default_nettype none
module rx_measure_and_irq_flags_test;
    logic        sys_clk, rst, reg_wr, reg_rd, synth_lock, intermediate_mode, continuous_mode;
    logic [5:0]  ev;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [2:0]  op_mode;
    wire logic [7:0]  reg_rdata, strength_sample;
    wire logic        corr_run, strength_run, corr_done, err_done, strength_sample_done;
    wire logic [15:0] corr_result, err_result;
    wire logic [30:0] outs;
    int          miscompares = 0, cmp_count = 0, runs = 0, dones = 0;
    rxmirq_bank uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .op_mode, .mode_reached(ev[3]), .intermediate_mode, .synth_lock, .gain_done(ev[4]),
        .continuous_mode, .bit_tick(ev[0]), .buffer_empty(ev[1]), .frame_start_det(ev[2]),
        .post_level_expired(ev[5]), .corr_done, .corr_result, .err_done, .err_result,
        .strength_sample_done, .strength_sample, .corr_run, .strength_run,
        .pin0_function(outs[30:29]), .pin1_function(outs[28:27]), .pin2_function(outs[26:25]),
        .pin3_function(outs[24:23]), .pin4_function(outs[22:21]), .pin5_function(outs[20:19]),
        .clock_output_divider(outs[18:16]), .rx_entry_wait(outs[15:8]),
        .post_level_wait(outs[7:0]));
    rxmirq_radio_model model (.sys_clk, .rst, .corr_run, .strength_run, .corr_done,
        .corr_result, .err_done, .err_result, .strength_sample_done, .strength_sample);
    // ****************************************
    // Bus and event tasks
    // ****************************************
    always @(posedge sys_clk) begin
        if (corr_run === 1'b1) runs++;
        if (corr_done === 1'b1) dones++;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Only masked bits are judged; the rest follow radio state
    task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata & m});
    endtask : rd
    task automatic pulse(input logic [5:0] p);
        @(posedge sys_clk);
        ev <= p;
        @(posedge sys_clk);
        ev <= 6'h00;
    endtask : pulse
    task automatic mode(input logic [2:0] m);
        @(posedge sys_clk);
        op_mode <= m;
    endtask : mode
    task automatic settle;
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            #1;
            if (dones == runs && strength_run === 1'b0) break;
        end
        chk("settle", 16'h0000, {15'h0000, i >= 200});
    endtask : settle
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [6:0] a[9] = '{7'h1f, 7'h20, 7'h23, 7'h24, 7'h25, 7'h26, 7'h29, 7'h2a, 7'h00};
        logic [7:0] e[9] = '{8'h00, 8'h00, 8'h02, 8'hff, 8'h00, 8'h07, 8'he4, 8'h00, 8'h00};
        for (int k = 0; k < 9; k++) rd(a[k], 8'hff, e[k]);
        wr(rxmirq_pkg::ADDR_CORR_HI, 8'h55);
        rd(rxmirq_pkg::ADDR_CORR_HI, 8'hff, 8'h00);
        wr(rxmirq_pkg::ADDR_PIN_SEL_A, 8'he4);
        rd(rxmirq_pkg::ADDR_PIN_SEL_A, 8'hff, 8'he4);
        wr(rxmirq_pkg::ADDR_PIN_SEL_B, 8'hff);
        rd(rxmirq_pkg::ADDR_PIN_SEL_B, 8'hff, 8'hf7);
        chk("pin outputs", 16'he4fe, outs[30:15]);
        $display("test reset and pins done");
    endtask : t_reset
    task automatic t_correction;
        logic [6:0] a[5] = '{7'h1f, 7'h20, 7'h21, 7'h22, 7'h1e};
        logic [7:0] e[5] = '{8'h81, 8'h23, 8'hfe, 8'h02, 8'h00};
        logic [7:0] c[3] = '{8'h04, 8'h08, 8'h0c};
        logic [15:0] mid[3] = '{16'h8123, 16'h8123, 16'h0000};
        int r0;
        wr(rxmirq_pkg::ADDR_CORR_CTRL, 8'h01);
        settle;
        chk("runs", 16'h0001, runs[15:0]);
        for (int k = 0; k < 5; k++) rd(a[k], 8'h0f << (k / 4 * 0) | 8'hf0 * (k < 4), e[k]);
        for (int k = 0; k < 3; k++) begin
            wr(rxmirq_pkg::ADDR_CORR_CTRL, c[k]);
            r0 = runs;
            mode(rxmirq_pkg::MODE_RX);
            @(posedge sys_clk);
            rd(rxmirq_pkg::ADDR_CORR_HI, 8'hff, mid[k][15:8]);
            rd(rxmirq_pkg::ADDR_CORR_LO, 8'hff, mid[k][7:0]);
            settle;
            chk("entry runs", {15'h0000, k != 1}, 16'(runs - r0));
            rd(rxmirq_pkg::ADDR_CORR_LO, 8'hff, 8'h23);
            mode(rxmirq_pkg::MODE_STBY);
        end
        wr(rxmirq_pkg::ADDR_CORR_CTRL, 8'h02);
        rd(rxmirq_pkg::ADDR_CORR_HI, 8'hff, 8'h81);
        mode(rxmirq_pkg::MODE_RX);
        wr(rxmirq_pkg::ADDR_CORR_CTRL, 8'h02);
        rd(rxmirq_pkg::ADDR_CORR_LO, 8'hff, 8'h00);
        mode(rxmirq_pkg::MODE_STBY);
        $display("test correction done");
    endtask : t_correction
    task automatic t_flags;
        wr(rxmirq_pkg::ADDR_STR_CTRL, 8'h01);
        rd(rxmirq_pkg::ADDR_STR_CTRL, 8'hff, 8'h00);
        settle;
        rd(rxmirq_pkg::ADDR_STR_CTRL, 8'hff, 8'h02);
        rd(rxmirq_pkg::ADDR_STR_LEVEL, 8'hff, 8'h50);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h08, 8'h00);
        wr(rxmirq_pkg::ADDR_RX_WAIT, 8'h01);
        wr(rxmirq_pkg::ADDR_POST_WAIT, 8'h3c);
        #1 chk("wait outputs", 16'h013c, outs[15:0]);
        mode(rxmirq_pkg::MODE_RX);
        repeat (15) pulse(6'h01);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h04, 8'h00);
        pulse(6'h01);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h04, 8'h04);
        pulse(6'h02);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h04, 8'h00);
        pulse(6'h04);
        wr(rxmirq_pkg::ADDR_FLAGS1, 8'h01);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h01, 8'h01);
        @(posedge sys_clk);
        continuous_mode <= 1'b1;
        wr(rxmirq_pkg::ADDR_FLAGS1, 8'h01);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h01, 8'h00);
        pulse(6'h08);
        synth_lock        <= 1'b1;
        intermediate_mode <= 1'b1;
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h92, 8'h92);
        wr(rxmirq_pkg::ADDR_STR_CTRL, 8'h01);
        settle;
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h08, 8'h08);
        wr(rxmirq_pkg::ADDR_FLAGS1, 8'h08);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h08, 8'h00);
        pulse(6'h20);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h04, 8'h04);
        wr(rxmirq_pkg::ADDR_CORR_CTRL, 8'h01);
        settle;
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h40, 8'h00);
        pulse(6'h10);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'h40, 8'h40);
        pulse(6'h04);
        mode(rxmirq_pkg::MODE_SLEEP);
        rd(rxmirq_pkg::ADDR_FLAGS1, 8'hdd, 8'h00);
        $display("test flags done");
    endtask : t_flags
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Scenarios need a few hundred cycles; the 30000-cycle limit allows about a hundred times that
    initial begin
        #300000;
        miscompares++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        tally_and_finish;
    end
    initial begin
        {rst, reg_wr, reg_rd, synth_lock, intermediate_mode, continuous_mode} = 6'h20;
        {ev, reg_addr, reg_wdata} = '0;
        op_mode = rxmirq_pkg::MODE_STBY;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_correction;
        t_flags;
        tally_and_finish;
    end
endmodule : rx_measure_and_irq_flags_test
`default_nettype wire
